//--- include/rmo_pkg.sv
package rmo_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] OFF_SEL_16_17 = 8'h00;
  localparam logic [7:0] OFF_SEL_18_19 = 8'h04;
  localparam logic [7:0] OFF_SEL_20_21 = 8'h08;
  localparam logic [7:0] OFF_SEL_22_23 = 8'h0C;
  localparam logic [7:0] OFF_SEL_24_25 = 8'h10;
  localparam int         NUM_REGS      = 5;
  localparam int         NUM_PINS      = 10;
  localparam int         FIRST_PIN     = 16;

  // Field layout inside each 16-bit register.
  localparam int         EVEN_LSB      = 0;
  localparam int         ODD_LSB       = 8;
  localparam int         CODE_W        = 5;
  localparam logic [15:0] IMPL_MASK    = 16'h1F1F;
  localparam logic [4:0]  CODE_RESET   = 5'h00;
  localparam logic [4:0]  CODE_NONE    = 5'h00;

  // Package variant selected at integration time.
  typedef enum {RMO_PKG_SMALL, RMO_PKG_LARGE} rmo_variant_t;

  // Returns the register index for an aligned offset, or NUM_REGS when unmapped.
  function automatic logic [2:0] rmo_decode(input logic [7:0] addr);
    case (addr)
      OFF_SEL_16_17: rmo_decode = 3'h0;
      OFF_SEL_18_19: rmo_decode = 3'h1;
      OFF_SEL_20_21: rmo_decode = 3'h2;
      OFF_SEL_22_23: rmo_decode = 3'h3;
      OFF_SEL_24_25: rmo_decode = 3'h4;
      default:       rmo_decode = 3'h5;
    endcase
  endfunction

endpackage

//--- hw/rmo_pin_route.sv
`timescale 1ns/1ps
module rmo_pin_route
  import rmo_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic [4:0]        func_code,
  input  wire logic [31:0]       periph_out,
  input  wire logic [31:0]       periph_oe,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   pin_remapped
);

  // Code zero leaves the pin unclaimed; any other code picks that peripheral.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_out      <= 1'b0;
      pin_oe       <= 1'b0;
      pin_remapped <= 1'b0;
    end else if (clk_en) begin
      if (func_code == CODE_NONE) begin
        pin_out      <= 1'b0;
        pin_oe       <= 1'b0;
        pin_remapped <= 1'b0;
      end else begin
        pin_out      <= periph_out[func_code];
        pin_oe       <= periph_oe[func_code];
        pin_remapped <= 1'b1;
      end
    end
  end

endmodule

//--- hw/rmo_out_select.sv
`timescale 1ns/1ps
// Functional notes
// - Bits 15..13 of each selection register read zero and ignore writes.
// - Bits 7..5 of each selection register always read zero.
// - Bits 12..8 hold the writable code for the odd pin of the register's pair.
// - Bits 4..0 hold the writable code for the even pin of the register's pair.
// - Every selection field is zero after reset.
// - The fields exist only on the large package; otherwise they read zero and hold nothing.
// - The five registers serve pin pairs 16/17 through 24/25 in order.
module rmo_out_select
  import rmo_pkg::*;
#(
  parameter rmo_variant_t VARIANT = RMO_PKG_LARGE
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [31:0]       periph_out,
  input  wire logic [31:0]       periph_oe,
  output logic [9:0]             remap_pin_out,
  output logic [9:0]             remap_pin_oe,
  output logic [9:0]             remap_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Selection storage: one code per pin, index 0 is pin 16.
  logic [4:0]  func_code [NUM_PINS];
  logic [2:0]  sel_idx;
  logic        setup;
  logic        present;
  logic [15:0] next_read;

  assign present = (VARIANT == RMO_PKG_LARGE);
  assign sel_idx = rmo_decode(paddr);
  // Answer is given one cycle after setup, so pready rises in the access phase.
  assign setup   = psel && !penable;

  // Read view of the addressed register; only implemented bits come through.
  always_comb begin
    next_read = 16'h0000;
    if (present && sel_idx < 3'(NUM_REGS)) begin
      next_read[ODD_LSB +: CODE_W]  = func_code[{sel_idx, 1'b1}];
      next_read[EVEN_LSB +: CODE_W] = func_code[{sel_idx, 1'b0}];
    end
    next_read = next_read & IMPL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes take effect at the access edge that sees pready high.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        func_code[i] <= CODE_RESET;
      end
    end else if (clk_en && present && psel && penable && pready && pwrite && sel_idx < 3'(NUM_REGS)) begin
      // Upper bits of each byte lane are dropped, since they hold no storage.
      if (pstrb[1]) begin
        func_code[{sel_idx, 1'b1}] <= pwdata[ODD_LSB +: CODE_W];
      end
      if (pstrb[0]) begin
        func_code[{sel_idx, 1'b0}] <= pwdata[EVEN_LSB +: CODE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: fixed one wait-free access phase, error on unmapped offsets.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup && (sel_idx >= 3'(NUM_REGS));
      if (setup && !pwrite) begin
        prdata <= {16'h0000, next_read};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One router per remappable pin; pin index k is physical pin 16+k.
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    rmo_pin_route u_route (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .func_code    (present ? func_code[k] : CODE_NONE),
      .periph_out   (periph_out),
      .periph_oe    (periph_oe),
      .pin_out      (remap_pin_out[k]),
      .pin_oe       (remap_pin_oe[k]),
      .pin_remapped (remap_active[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  reserved_read_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pready |-> (prdata[15:13] == 3'h0 && prdata[31:16] == 16'h0000))
    else $error("reserved upper bits read nonzero");

  gap_bits_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pready |-> prdata[7:5] == 3'h0)
    else $error("bits 7..5 read nonzero");

  odd_write_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && present && setup && pwrite && pstrb[1] && sel_idx < 3'(NUM_REGS))
    ##1 (clk_en && pready) |=> func_code[{$past(sel_idx, 2), 1'b1}] == $past(pwdata[12:8], 2))
    else $error("odd pin code not stored");

  even_write_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && present && setup && pwrite && pstrb[0] && sel_idx < 3'(NUM_REGS))
    ##1 (clk_en && pready) |=> func_code[{$past(sel_idx, 2), 1'b0}] == $past(pwdata[4:0], 2))
    else $error("even pin code not stored");

  reset_zero_a: assert property (@(posedge clk_sys)
    !rst_n |=> (func_code[0] == CODE_RESET && func_code[9] == CODE_RESET && remap_active == 10'h000))
    else $error("selection not zero after reset");

  small_pkg_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!present && pready) |-> prdata == 32'h0000_0000)
    else $error("small package read nonzero");

  pair_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && setup && !pwrite && present && paddr == OFF_SEL_24_25) |=>
    (prdata[12:8] == func_code[9] && prdata[4:0] == func_code[8]))
    else $error("last register not pins 24 and 25");

  code_zero_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && present && func_code[0] == CODE_NONE) |=> (!remap_active[0] && !remap_pin_oe[0]))
    else $error("pin 16 driven with code zero");

endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import rmo_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] periph_out = 32'hA5C3_5A3C;
  logic [31:0] periph_oe  = 32'h3CA5_C35A;
  logic [31:0] prdata, prdata_s, rd, rs;
  logic        pready, pslverr, err;
  logic [9:0]  remap_pin_out, remap_pin_oe, remap_active, act_s;
  logic [4:0]  code;
  int          n_errors  = 0;
  int          cmp_count = 0;
  // Each row sets some unused bits high so that any leak into read data shows.
  logic [31:0] wr_row [5] = '{32'hFFFF_FFE1, 32'h0000_E2E0, 32'h1234_5A7C, 32'hFFFF_A0BF, 32'h0000_6D33};
  logic [31:0] ex_row [5] = '{32'h0000_1F01, 32'h0000_0200, 32'h0000_1A1C, 32'h0000_001F, 32'h0000_0D13};

  rmo_out_select u_dut (.clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .periph_out, .periph_oe, .remap_pin_out, .remap_pin_oe, .remap_active);
  // The small variant shares the bus; only its read data and pin flags are watched.
  rmo_out_select #(.VARIANT(RMO_PKG_SMALL)) u_small (.clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata(prdata_s), .pready(), .pslverr(), .periph_out, .periph_oe, .remap_pin_out(),
    .remap_pin_oe(), .remap_active(act_s));

  // The clock toggles every 25 ns, a period of 50 ns.
  always #25 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the wait for pready is bounded so a hang ends the run.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 8);
    rd = prdata;
    rs = prdata_s;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Writes all rows before reading any back, so aliased registers are caught.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'(4 * i), wr_row[i]);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, ex_row[i]);
      chk(rs, 32'h0);
    end
    chk(32'(act_s), 32'h0);
    for (int k = 0; k < 10; k++) begin
      code = k[0] ? ex_row[k / 2][12:8] : ex_row[k / 2][4:0];
      chk({remap_active[k], remap_pin_out[k], remap_pin_oe[k]}, {code != 0, code != 0 && periph_out[code], code != 0 && periph_oe[code]});
    end
    // A single-lane write must touch only the code behind that lane.
    pstrb <= 4'h1;
    apb(1'b1, 8'h00, 32'h0000_0A05);
    pstrb <= 4'hF;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_1F05);
    // With the clock enable low a pending setup is neither answered nor written.
    @(posedge clk_sys);
    clk_en  <= 1'b0;
    psel    <= 1'b1;
    pwrite  <= 1'b1;
    paddr   <= 8'h04;
    pwdata  <= 32'h0000_1F1F;
    repeat (3) @(posedge clk_sys);
    chk(32'(pready), 32'h0);
    psel    <= 1'b0;
    pwrite  <= 1'b0;
    clk_en  <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, ex_row[1]);
    // An unmapped write must be refused and change nothing.
    apb(1'b1, 8'h14, 32'h0000_1F1F);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, ex_row[4]);
    // A second reset in mid-run clears every selection.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    chk(32'(remap_active), 32'h0);
    complete_run();
  end
endmodule
